/* File: logic/cwg_deadband.sv */
`timescale 1ns/1ps
module cwg_deadband (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire cwg_pkg::bus_req_s busReq,
    output logic [cwg_pkg::DATA_W-1:0] rdData,
    // Data sources and system status
    input wire logic [cwg_pkg::NUM_SRC-1:0] sourceBus,
    input wire logic sleepMode,
    input wire logic shutdownReq,
    // Bridge drive outputs
    output logic out_a,
    output logic out_b,
    output logic out_c,
    output logic out_d,
    output logic fastOscKeepAlive
);
    cwg_pkg::state_s st;
    cwg_pkg::state_s next_st;

    logic dataIn;
    logic riseEdge;
    logic fallEdge;
    logic dbTick;
    logic loadNow;
    logic isHalf;
    logic isFull;
    logic newDir;
    logic [cwg_pkg::DB_W-1:0] risingEff;
    logic [cwg_pkg::DB_W-1:0] fallingEff;
    logic [cwg_pkg::DB_W-1:0] target;
    logic [cwg_pkg::DB_W-1:0] cntInc;
    logic [cwg_pkg::PHASE_W:0] accSum;
    logic [cwg_pkg::NUM_OUT-1:0] drvNext;
    logic [cwg_pkg::DATA_W-1:0] rdValue;

    // Data select, edges, tick and buffered counts
    always_comb begin
        dataIn = 1'b0;
        if (st.dataSourceSelect < 4'(cwg_pkg::NUM_SRC)) begin
            dataIn = sourceBus[st.dataSourceSelect]; // RULE4
        end
        riseEdge = dataIn & ~st.dPrev; // RULE11
        fallEdge = ~dataIn & st.dPrev; // RULE11
        accSum = {1'b0, st.oscAcc} + 6'(cwg_pkg::OSC_MHZ);
        // Oscillator ticks 16 of every 20 cycles; system clock stops in Sleep
        if (st.clkSel) begin
            dbTick = accSum >= 6'(cwg_pkg::SYS_CLK_MHZ); // RULE2 RULE20
        end else begin
            dbTick = ~sleepMode; // RULE2 RULE3
        end
        isHalf = st.mode == cwg_pkg::MODE_HALF;
        isFull = (st.mode == cwg_pkg::MODE_FWD) || (st.mode == cwg_pkg::MODE_REV);
        newDir = st.mode == cwg_pkg::MODE_REV;
        loadNow = st.en & st.deadbandLoadRequest & st.ldArmed & riseEdge; // RULE19
        risingEff = loadNow ? st.risingBuf : st.risingWork;
        fallingEff = loadNow ? st.fallingBuf : st.fallingWork;
        target = (st.phase == cwg_pkg::DB_RISE) ? st.risingWork : st.fallingWork;
        cntInc = st.dbCnt + 6'h01;
        rdValue = 8'h00;
        unique case (busReq.addr)
            cwg_pkg::REG_CTRL: rdValue = {st.en, st.deadbandLoadRequest, 3'h0, st.mode};
            cwg_pkg::REG_POL: rdValue = {4'h0, st.outputPolarity};
            cwg_pkg::REG_SRC: rdValue = {4'h0, st.dataSourceSelect};
            cwg_pkg::REG_DBR: rdValue = {2'h0, st.risingBuf};
            cwg_pkg::REG_DBF: rdValue = {2'h0, st.fallingBuf};
            cwg_pkg::REG_CLK: rdValue = {7'h00, st.clkSel};
            cwg_pkg::REG_OVR: rdValue = {4'h0, st.ovrLevel};
            cwg_pkg::REG_STAT: rdValue = {st.outs, st.ldArmed, st.dir,
                                          st.phase != cwg_pkg::DB_IDLE, 1'b0};
        endcase
    end

    // Next state: dead-band sequencing, load buffers, register writes
    always_comb begin
        next_st = st;
        next_st.dPrev = dataIn;
        next_st.oscAcc = st.clkSel && (accSum >= 6'(cwg_pkg::SYS_CLK_MHZ))
            ? 5'(accSum - 6'(cwg_pkg::SYS_CLK_MHZ)) : 5'(accSum);
        next_st.keepAlive = st.en & st.clkSel & sleepMode; // RULE3
        next_st.rdData = busReq.rd ? rdValue : 8'h00;
        // Arm on first falling edge after the load request, load on next rise
        if (st.en && st.deadbandLoadRequest && fallEdge) begin
            next_st.ldArmed = 1'b1; // RULE19
        end
        if (loadNow) begin
            next_st.risingWork = st.risingBuf; // RULE19
            next_st.fallingWork = st.fallingBuf; // RULE19
            next_st.deadbandLoadRequest = 1'b0; // RULE25
            next_st.ldArmed = 1'b0; // RULE25
        end
        if (!st.en) begin
            // Disabled: drives cleared, direction follows the mode field
            next_st.hiOn = 1'b0; // RULE5
            next_st.loOn = 1'b0; // RULE5
            next_st.phase = cwg_pkg::DB_IDLE;
            next_st.dbCnt = 6'h00;
            next_st.dir = newDir;
            next_st.ldArmed = 1'b0;
        end else if (isHalf) begin
            // Half bridge: A after rising count, B after falling count
            if (riseEdge) begin
                next_st.loOn = 1'b0;
                next_st.dbCnt = 6'h00; // RULE26
                if (risingEff == 6'h00) begin
                    next_st.hiOn = 1'b1; // RULE16
                    next_st.phase = cwg_pkg::DB_IDLE;
                end else begin
                    next_st.phase = cwg_pkg::DB_RISE; // RULE12
                end
            end else if (fallEdge) begin
                next_st.hiOn = 1'b0; // RULE18
                next_st.dbCnt = 6'h00; // RULE26
                if (fallingEff == 6'h00) begin
                    next_st.loOn = 1'b1; // RULE17
                    next_st.phase = cwg_pkg::DB_IDLE;
                end else begin
                    next_st.phase = cwg_pkg::DB_FALL; // RULE13
                end
            end else if (dbTick && st.phase != cwg_pkg::DB_IDLE) begin
                next_st.dbCnt = cntInc; // RULE10
                if (cntInc == target) begin
                    next_st.phase = cwg_pkg::DB_IDLE; // RULE26
                    if (st.phase == cwg_pkg::DB_RISE) begin
                        next_st.hiOn = 1'b1; // RULE12
                    end else begin
                        next_st.loOn = 1'b1; // RULE13
                    end
                end
            end
        end else if (isFull) begin
            // Full bridge: hiOn is the modulated output's drive
            next_st.loOn = 1'b0;
            if (riseEdge) begin
                next_st.dbCnt = 6'h00; // RULE26
                next_st.hiOn = 1'b1;
                next_st.phase = cwg_pkg::DB_IDLE;
                if (newDir != st.dir) begin
                    next_st.dir = newDir; // RULE24
                    if (newDir && risingEff != 6'h00) begin
                        next_st.hiOn = 1'b0; // RULE14 RULE1
                        next_st.phase = cwg_pkg::DB_RISE; // RULE14
                    end else if (!newDir && fallingEff != 6'h00) begin
                        next_st.hiOn = 1'b0; // RULE15 RULE1
                        next_st.phase = cwg_pkg::DB_FALL; // RULE15
                    end
                end
            end else if (fallEdge) begin
                next_st.hiOn = 1'b0; // RULE18
                next_st.phase = cwg_pkg::DB_IDLE; // RULE18
            end else if (dbTick && st.phase != cwg_pkg::DB_IDLE) begin
                next_st.dbCnt = cntInc; // RULE10
                if (cntInc == target) begin
                    next_st.phase = cwg_pkg::DB_IDLE;
                    next_st.hiOn = 1'b1; // RULE26
                end
            end
        end else begin
            // Other modes run without dead band
            next_st.hiOn = dataIn; // RULE9
            next_st.loOn = ~dataIn; // RULE9
            next_st.phase = cwg_pkg::DB_IDLE; // RULE9
        end
        // Map logical drives onto the four outputs
        drvNext = 4'h0;
        if (st.en && isFull) begin
            drvNext[cwg_pkg::OUT_A] = ~next_st.dir; // RULE22 RULE1
            drvNext[cwg_pkg::OUT_C] = next_st.dir; // RULE23 RULE1
            drvNext[cwg_pkg::OUT_B] = next_st.dir & next_st.hiOn; // RULE23
            drvNext[cwg_pkg::OUT_D] = ~next_st.dir & next_st.hiOn; // RULE22
        end else if (st.en) begin
            drvNext = {next_st.loOn, next_st.hiOn, next_st.loOn, next_st.hiOn};
        end
        next_st.drv = drvNext;
        // Override ignores polarity; otherwise polarity inverts each drive
        next_st.outs = shutdownReq ? st.ovrLevel : drvNext ^ st.outputPolarity; // RULE6 RULE7
        // Register writes; a software load request wins over the hardware clear
        if (busReq.wr) begin
            unique case (busReq.addr)
                cwg_pkg::REG_CTRL: begin
                    next_st.en = busReq.wdata[cwg_pkg::CTRL_EN_BIT];
                    next_st.deadbandLoadRequest = busReq.wdata[cwg_pkg::CTRL_LD_BIT];
                    next_st.mode = busReq.wdata[cwg_pkg::MODE_W-1:0];
                    if (busReq.wdata[cwg_pkg::CTRL_LD_BIT] && !st.deadbandLoadRequest) begin
                        next_st.ldArmed = 1'b0;
                    end
                end
                cwg_pkg::REG_POL: next_st.outputPolarity = busReq.wdata[3:0]; // RULE6
                cwg_pkg::REG_SRC: next_st.dataSourceSelect = busReq.wdata[3:0]; // RULE4
                cwg_pkg::REG_DBR: begin
                    next_st.risingBuf = busReq.wdata[cwg_pkg::DB_W-1:0]; // RULE8
                    if (!st.en) begin
                        next_st.risingWork = busReq.wdata[cwg_pkg::DB_W-1:0]; // RULE19
                    end
                end
                cwg_pkg::REG_DBF: begin
                    next_st.fallingBuf = busReq.wdata[cwg_pkg::DB_W-1:0]; // RULE8
                    if (!st.en) begin
                        next_st.fallingWork = busReq.wdata[cwg_pkg::DB_W-1:0]; // RULE19
                    end
                end
                cwg_pkg::REG_CLK: next_st.clkSel = busReq.wdata[0]; // RULE2
                cwg_pkg::REG_OVR: next_st.ovrLevel = busReq.wdata[3:0]; // RULE7
                cwg_pkg::REG_STAT: begin
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.mode <= cwg_pkg::RST_MODE;
            st.outputPolarity <= cwg_pkg::RST_POL;
            st.ovrLevel <= cwg_pkg::RST_OVR;
            st.dataSourceSelect <= cwg_pkg::RST_SRC;
            st.risingBuf <= cwg_pkg::RST_DB;
            st.fallingBuf <= cwg_pkg::RST_DB;
            st.risingWork <= cwg_pkg::RST_DB;
            st.fallingWork <= cwg_pkg::RST_DB;
            st.phase <= cwg_pkg::DB_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign out_a = st.outs[cwg_pkg::OUT_A];
    assign out_b = st.outs[cwg_pkg::OUT_B];
    assign out_c = st.outs[cwg_pkg::OUT_C];
    assign out_d = st.outs[cwg_pkg::OUT_D];
    assign fastOscKeepAlive = st.keepAlive;
    assign rdData = st.rdData;

    // Checks on the dead-band sequencing, drive mapping and override level
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sequence halfRise;
        st.en && isHalf && riseEdge && !busReq.wr;
    endsequence
    sequence halfFall;
        st.en && isHalf && fallEdge && !busReq.wr;
    endsequence

    disabled_clear_a: assert property ((!st.en && !busReq.wr) |=> st.drv == 4'h0) // RULE5
        else $error("drives not cleared while disabled");
    override_level_a: assert property (shutdownReq |=> st.outs == $past(st.ovrLevel)) // RULE7
        else $error("override level altered");
    rise_delay_a: assert property ((halfRise and (risingEff != 6'h00)) // RULE12
        |=> !st.hiOn && st.phase == cwg_pkg::DB_RISE)
        else $error("output A not delayed after rising edge");
    rise_zero_a: assert property ((halfRise and (risingEff == 6'h00)) |=> st.hiOn) // RULE16
        else $error("zero rising count still delayed");
    fall_zero_a: assert property ((halfFall and (fallingEff == 6'h00)) |=> st.loOn) // RULE17
        else $error("zero falling count still delayed");
    early_cancel_a: assert property ((halfFall and (st.phase == cwg_pkg::DB_RISE)) // RULE18
        |=> !st.hiOn && st.phase != cwg_pkg::DB_RISE)
        else $error("pulse after cancelled rising dead band");
    count_step_a: assert property ((st.en && (isHalf || isFull) && dbTick && !riseEdge // RULE10
        && !fallEdge && !busReq.wr && st.phase != cwg_pkg::DB_IDLE && cntInc != target)
        |=> st.dbCnt == $past(cntInc) && st.phase == $past(st.phase))
        else $error("dead-band count did not step");
    fwd_static_a: assert property ((st.en && $past(st.en) && st.mode == cwg_pkg::MODE_FWD // RULE22
        && !st.dir) |-> st.drv[cwg_pkg::OUT_A] && !st.drv[cwg_pkg::OUT_B]
        && !st.drv[cwg_pkg::OUT_C])
        else $error("forward static outputs wrong");
    rev_static_a: assert property ((st.en && $past(st.en) && st.mode == cwg_pkg::MODE_REV // RULE23
        && st.dir) |-> st.drv[cwg_pkg::OUT_C] && !st.drv[cwg_pkg::OUT_A]
        && !st.drv[cwg_pkg::OUT_D])
        else $error("reverse static outputs wrong");
    dir_at_edge_a: assert property ((st.en && $changed(st.dir) && $past(st.en)) // RULE24
        |-> $past(riseEdge))
        else $error("direction changed off a rising edge");
    load_clear_a: assert property ((loadNow && !busReq.wr) // RULE25
        |=> !st.deadbandLoadRequest && st.risingWork == $past(st.risingBuf))
        else $error("load request not cleared after transfer");
endmodule

/* File: include/cwg_pkg.sv */
// Function
// [RULE1] Full bridge: dead band only on direction change, only on modulated output.
// [RULE2] One select bit picks system clock or 16 MHz internal oscillator for dead band.
// [RULE3] Selected internal oscillator keeps running in Sleep; dead band keeps working.
// [RULE4] Four-bit select picks the data input from fourteen sources.
// [RULE5] On enable every output drive starts cleared.
// [RULE6] Per-output polarity bit: set means active-low, clear means active-high.
// [RULE7] Polarity never changes the shutdown override levels.
// [RULE8] Two independent 6-bit counts: rising-edge delay and falling-edge delay.
// [RULE9] Dead band applies only in half-bridge and full-bridge modes.
// [RULE10] Interval counts dead-band clock periods from zero up to the value.
// [RULE11] Each interval starts only at a data input edge.
// [RULE12] Half bridge: output A turn-on delayed after rising edge by rising count.
// [RULE13] Half bridge: output B turn-on delayed after falling edge by falling count.
// [RULE14] Full bridge: forward to reverse inserts rising count, delaying output B only.
// [RULE15] Full bridge: reverse to forward inserts falling count, delaying output D only.
// [RULE16] Rising interval spans 0 to 64 periods; zero means no dead band.
// [RULE17] Falling interval spans zero to 64 periods likewise.
// [RULE18] Data reversing before count ends gives no pulse on that output.
// [RULE19] Counts double-buffered; load at once when off, else at armed rising edge.
// [RULE20] Dead band may vary by at most one dead-band clock period.
// [RULE21] Firmware should cut duty for one period before a direction change.
// [RULE22] Forward mode 010: A active, D modulated, B and C inactive.
// [RULE23] Reverse mode 011: C active, B modulated, A and D inactive.
// [RULE24] Direction change takes effect at next rising data edge.
// [RULE25] Hardware clears load request once working counts are loaded.
// [RULE26] Counter restarts at each qualifying edge; output turns on at working value.
package cwg_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int DB_W = 6;
    localparam int SRC_W = 4;
    localparam int NUM_SRC = 14;
    localparam int NUM_OUT = 4;
    localparam int MODE_W = 3;
    localparam int PHASE_W = 5;
    // Clock rates for the oscillator tick generator
    localparam int SYS_CLK_MHZ = 20;
    localparam int OSC_MHZ = 16;
    // Register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] REG_POL = 3'h1;
    localparam logic [ADDR_W-1:0] REG_SRC = 3'h2;
    localparam logic [ADDR_W-1:0] REG_DBR = 3'h3;
    localparam logic [ADDR_W-1:0] REG_DBF = 3'h4;
    localparam logic [ADDR_W-1:0] REG_CLK = 3'h5;
    localparam logic [ADDR_W-1:0] REG_OVR = 3'h6;
    localparam logic [ADDR_W-1:0] REG_STAT = 3'h7;
    // Field positions
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_LD_BIT = 6;
    localparam int STAT_OUT_LSB = 4;
    localparam int STAT_ARM_BIT = 3;
    localparam int STAT_DIR_BIT = 2;
    localparam int STAT_RUN_BIT = 1;
    localparam int OUT_A = 0;
    localparam int OUT_B = 1;
    localparam int OUT_C = 2;
    localparam int OUT_D = 3;
    // Mode codes
    localparam logic [MODE_W-1:0] MODE_FWD = 3'h2;
    localparam logic [MODE_W-1:0] MODE_REV = 3'h3;
    localparam logic [MODE_W-1:0] MODE_HALF = 3'h4;
    // Reset values
    localparam logic [MODE_W-1:0] RST_MODE = 3'h0;
    localparam logic [NUM_OUT-1:0] RST_POL = 4'h0;
    localparam logic [NUM_OUT-1:0] RST_OVR = 4'h0;
    localparam logic [SRC_W-1:0] RST_SRC = 4'h0;
    localparam logic [DB_W-1:0] RST_DB = 6'h00;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_s;

    typedef enum logic [2:0] {
        DB_IDLE = 3'b001,
        DB_RISE = 3'b010,
        DB_FALL = 3'b100
    } db_phase_e;

    typedef struct packed {
        logic en;
        logic deadbandLoadRequest;
        logic ldArmed;
        logic [MODE_W-1:0] mode;
        logic dir;
        logic [NUM_OUT-1:0] outputPolarity;
        logic [SRC_W-1:0] dataSourceSelect;
        logic [DB_W-1:0] risingBuf;
        logic [DB_W-1:0] fallingBuf;
        logic [DB_W-1:0] risingWork;
        logic [DB_W-1:0] fallingWork;
        logic clkSel;
        logic [NUM_OUT-1:0] ovrLevel;
        logic dPrev;
        db_phase_e phase;
        logic [DB_W-1:0] dbCnt;
        logic hiOn;
        logic loOn;
        logic [NUM_OUT-1:0] drv;
        logic [NUM_OUT-1:0] outs;
        logic keepAlive;
        logic [PHASE_W-1:0] oscAcc;
        logic [DATA_W-1:0] rdData;
    } state_s;
endpackage

/* File: tb/bridge_driver_model.sv */
`timescale 1ns/1ps
module bridge_driver_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Drive pins, their active levels and the watch window
    input wire logic [3:0] driveOut,
    input wire logic [3:0] activeLow,
    input wire logic watch,
    // Switch state seen by the bridge
    output logic [3:0] switchOn,
    output logic [7:0] shootCount
);
    // A driver turns its switch on at its active level
    assign switchOn = driveOut ^ activeLow;

    // Count cycles where both switches of one leg conduct
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            shootCount <= 8'h00;
        end else if (watch && ((switchOn[0] && switchOn[1]) || (switchOn[2] && switchOn[3]))) begin
            shootCount <= shootCount + 8'h01;
        end
    end
endmodule

/* File: tb/complementary_deadband_output_bench.sv */
`timescale 1ns/1ps
module complementary_deadband_output_bench;
    // Stimulus, observed outputs and bookkeeping
    logic core_clk;
    logic reset_n;
    cwg_pkg::bus_req_s busReq;
    logic [cwg_pkg::NUM_SRC-1:0] sourceBus;
    logic sleepMode, shutdownReq, watch, fastOscKeepAlive;
    logic out_a, out_b, out_c, out_d;
    logic [7:0] rdData, shootCount;
    logic [3:0] pol, outs, switchOn;
    int miscompares, testsRun, sel, v, f;
    assign outs = {out_d, out_c, out_b, out_a};

    cwg_deadband i_cwg_deadband (.core_clk(core_clk), .reset_n(reset_n), .busReq(busReq),
        .rdData(rdData), .sourceBus(sourceBus), .sleepMode(sleepMode),
        .shutdownReq(shutdownReq), .out_a(out_a), .out_b(out_b), .out_c(out_c),
        .out_d(out_d), .fastOscKeepAlive(fastOscKeepAlive));
    bridge_driver_model i_bridge_driver_model (.core_clk(core_clk), .reset_n(reset_n),
        .driveOut(outs), .activeLow(pol), .watch(watch), .switchOn(switchOn),
        .shootCount(shootCount));

    // Expected drive pattern {D,C,B,A} per mode and data level
    function automatic logic [3:0] bridge(logic [2:0] mode, logic d);
        if (mode == cwg_pkg::MODE_FWD) return {d, 1'b0, 1'b0, 1'b1};
        if (mode == cwg_pkg::MODE_REV) return {1'b0, 1'b1, d, 1'b0};
        return {~d, d, ~d, d};
    endfunction
    function automatic logic [7:0] ctrl(logic en, logic ld, logic [2:0] mode);
        return {en, ld, 3'h0, mode};
    endfunction

    // Compare helpers
    task automatic chkVal(logic [7:0] got, logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkRange(int n, int lo, int hi);
        testsRun++;
        if (n < lo || n > hi) begin
            miscompares++;
            $display("[FAIL] %0t delay %0d outside %0d..%0d", $time, n, lo, hi);
        end
    endtask

    // Bus cycles and pacing, entered just after a rising edge
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        busReq <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        busReq <= '0;
        @(posedge core_clk);
    endtask
    task automatic rd(logic [2:0] a, logic [7:0] exp);
        busReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk);
        busReq <= '0;
        #1;
        chkVal(rdData, exp);
        @(posedge core_clk);
    endtask
    task automatic setData(logic d);
        logic [cwg_pkg::NUM_SRC-1:0] r;
        r = cwg_pkg::NUM_SRC'($urandom);
        if (sel < cwg_pkg::NUM_SRC) r[sel] = d;
        sourceBus <= r;
    endtask
    task automatic look(logic k, logic [3:0] o);
        #1;
        chkVal({3'h0, fastOscKeepAlive, outs}, {3'h0, k, o});
        @(posedge core_clk);
    endtask
    task automatic measure(int idx, int lo, int hi);
        int n;
        n = 0;
        #1;
        while (n < 200 && outs[idx] !== 1'b1) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chkRange(n, lo, hi);
        @(posedge core_clk);
    endtask
    task automatic quiet(int idx, int cycles);
        int hits;
        hits = 0;
        repeat (cycles) begin
            @(posedge core_clk);
            #1;
            if (outs[idx] !== 1'b0) hits++;
        end
        chkVal(8'(hits), 8'h00);
        @(posedge core_clk);
    endtask
    task automatic end_sim();
        if (miscompares == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Watchdog sized well beyond the expected run
    initial begin
        #1000000;
        miscompares++;
        end_sim();
    end

    // Main sequence
    initial begin
        busReq = '0;
        sourceBus = '0;
        {sleepMode, shutdownReq, watch, reset_n} = 4'h0;
        {pol, miscompares, testsRun, sel} = '0;
        void'($urandom(32'h8dc0));
        tick(6);
        reset_n <= 1'b1;
        @(posedge core_clk);
        look(1'b0, 4'h0);
        rd(cwg_pkg::REG_STAT, 8'h00);
        wr(cwg_pkg::REG_POL, 8'h0F);
        look(1'b0, 4'hF);
        wr(cwg_pkg::REG_STAT, 8'hFF);
        rd(cwg_pkg::REG_STAT, 8'hF0);
        wr(cwg_pkg::REG_OVR, 8'h05);
        shutdownReq <= 1'b1;
        tick(2);
        look(1'b0, 4'h5);
        shutdownReq <= 1'b0;
        // Every source code in pass-through, random polarity
        wr(cwg_pkg::REG_DBR, 8'h05);
        wr(cwg_pkg::REG_CTRL, ctrl(1'b1, 1'b0, 3'h0));
        for (int s = 0; s < 16; s++) begin
            pol = 4'($urandom);
            sel = s;
            wr(cwg_pkg::REG_POL, {4'h0, pol});
            wr(cwg_pkg::REG_SRC, 8'(s));
            for (int d = 1; d >= 0; d--) begin
                setData(d[0]);
                tick(2);
                look(1'b0, bridge(3'h0, d[0] && s < 14) ^ pol);
            end
        end
        pol = 4'h0;
        wr(cwg_pkg::REG_POL, 8'h00);
        wr(cwg_pkg::REG_CTRL, 8'h00);
        // Half bridge delays at both ends of the count range
        watch <= 1'b1;
        sel = $urandom % 14;
        wr(cwg_pkg::REG_SRC, 8'(sel));
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 0 : (k == 3) ? 63 : 1 + $urandom % 62;
            f = (k == 0) ? 63 : (k == 3) ? 0 : $urandom % 64;
            wr(cwg_pkg::REG_DBR, 8'(v));
            wr(cwg_pkg::REG_DBF, 8'(f));
            wr(cwg_pkg::REG_CTRL, ctrl(1'b1, 1'b0, cwg_pkg::MODE_HALF));
            setData(1'b0);
            tick(70);
            setData(1'b1);
            measure(cwg_pkg::OUT_A, v + 1, v + 2);
            setData(1'b0);
            measure(cwg_pkg::OUT_B, f + 1, f + 2);
            wr(cwg_pkg::REG_CTRL, 8'h00);
        end
        // Pulse shorter than the count, then a buffered reload
        wr(cwg_pkg::REG_DBR, 8'h0A);
        wr(cwg_pkg::REG_CTRL, ctrl(1'b1, 1'b0, cwg_pkg::MODE_HALF));
        tick(70);
        setData(1'b1);
        tick(4);
        setData(1'b0);
        quiet(cwg_pkg::OUT_A, 20);
        wr(cwg_pkg::REG_DBR, 8'h03);
        wr(cwg_pkg::REG_CTRL, ctrl(1'b1, 1'b1, cwg_pkg::MODE_HALF));
        rd(cwg_pkg::REG_CTRL, ctrl(1'b1, 1'b1, cwg_pkg::MODE_HALF));
        setData(1'b1);
        measure(cwg_pkg::OUT_A, 11, 12);
        setData(1'b0);
        tick(20);
        setData(1'b1);
        measure(cwg_pkg::OUT_A, 4, 5);
        rd(cwg_pkg::REG_CTRL, ctrl(1'b1, 1'b0, cwg_pkg::MODE_HALF));
        // Full bridge direction changes with duty dropped first
        wr(cwg_pkg::REG_CTRL, 8'h00);
        wr(cwg_pkg::REG_DBR, 8'h08);
        wr(cwg_pkg::REG_DBF, 8'h0C);
        wr(cwg_pkg::REG_CTRL, ctrl(1'b1, 1'b0, cwg_pkg::MODE_FWD));
        // Data is still high from the reload test: drop it so a fresh rise drives D
        setData(1'b0);
        tick(2);
        setData(1'b1);
        tick(20);
        look(1'b0, bridge(cwg_pkg::MODE_FWD, 1'b1));
        setData(1'b0);
        tick(20);
        look(1'b0, bridge(cwg_pkg::MODE_FWD, 1'b0));
        wr(cwg_pkg::REG_CTRL, ctrl(1'b1, 1'b0, cwg_pkg::MODE_REV));
        tick(5);
        look(1'b0, bridge(cwg_pkg::MODE_FWD, 1'b0));
        setData(1'b1);
        measure(cwg_pkg::OUT_B, 9, 10);
        look(1'b0, bridge(cwg_pkg::MODE_REV, 1'b1));
        setData(1'b0);
        tick(20);
        setData(1'b1);
        measure(cwg_pkg::OUT_B, 1, 2);
        setData(1'b0);
        tick(20);
        wr(cwg_pkg::REG_CTRL, ctrl(1'b1, 1'b0, cwg_pkg::MODE_FWD));
        setData(1'b1);
        measure(cwg_pkg::OUT_D, 13, 14);
        // Oscillator clock times the dead band through sleep
        wr(cwg_pkg::REG_CTRL, 8'h00);
        wr(cwg_pkg::REG_DBR, 8'h10);
        wr(cwg_pkg::REG_CLK, 8'h01);
        wr(cwg_pkg::REG_CTRL, ctrl(1'b1, 1'b0, cwg_pkg::MODE_FWD));
        sleepMode <= 1'b1;
        setData(1'b0);
        tick(10);
        look(1'b1, bridge(cwg_pkg::MODE_FWD, 1'b0));
        wr(cwg_pkg::REG_CTRL, ctrl(1'b1, 1'b0, cwg_pkg::MODE_REV));
        setData(1'b1);
        measure(cwg_pkg::OUT_B, 17, 24);
        sleepMode <= 1'b0;
        wr(cwg_pkg::REG_CLK, 8'h00);
        tick(2);
        look(1'b0, bridge(cwg_pkg::MODE_REV, 1'b1));
        #1;
        chkVal(shootCount, 8'h00);
        end_sim();
    end
endmodule
